// ---- tx_abort_cause.sv ----
/*
 * Transmit-abort cause capture of a two-wire bus controller acting as
 * master, slave or both. Collects abort causes into a read-only 16-bit
 * register, raises the abort status and asks the FIFO to flush.
 * Assumes master/slave state machines and FIFO on sys_clk_in; the bus
 * lines scl/sda arrive asynchronously and are synchronised here.
 */
`timescale 1ns/100ps
`include "tx_abort_params.svh"

module tx_abort_cause
   import tx_abort_pkg::*;
(
   // clock and reset
   input  wire logic          sys_clk_in,
   input  wire logic          nrst_in,
   // register port
   input  wire logic [31:0]   reg_addr_in,
   input  wire logic [15:0]   reg_wdata_in,
   input  wire logic          reg_wr_in,
   input  wire logic          reg_rd_in,
   output logic      [15:0]   reg_rdata_out,
   // bus lines, asynchronous
   input  wire logic          scl_in,
   input  wire logic          sda_in,
   // master state machine
   input  wire master_event_t master_event_in,
   input  wire logic          master_cmd_pending_in,
   input  wire logic          master_read_issue_in,
   input  wire logic          master_idle_in,
   input  wire logic          master_tx_drive_in,
   input  wire logic          master_tx_bit_in,
   // slave state machine and transmit FIFO
   input  wire logic          slave_read_req_in,
   input  wire logic          slave_tx_active_in,
   input  wire logic          slave_tx_bit_in,
   input  wire logic          tx_fifo_empty_in,
   // abort reaction
   output logic               tx_flush_out,
   output logic               master_stop_out,
   output logic               slave_stop_out,
   output logic               transmit_abort_event_out,
   output logic               master_bus_lost_out,
   output logic               slave_bus_lost_out
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   abort_state_t q;
   abort_state_t d;

   logic        wr_ctrl;
   logic        wr_target;
   logic        wr_dcmd;
   logic        clear_all;
   logic        scl_rise;
   logic        restart_ok;
   logic        master_on;
   logic        high_speed;
   logic        ten_bit;
   logic        sbyte_cause;
   logic        dis_cause;
   logic        hs_cause;
   logic        master_lost;
   logic        slave_lost;
   logic [15:0] set;
   logic [15:0] evt;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      d = q;

      wr_ctrl   = reg_wr_in && (reg_addr_in == `ADDR_CONTROLLER_CONFIG);
      wr_target = reg_wr_in && (reg_addr_in == `ADDR_TARGET_ADDRESS_CFG);
      wr_dcmd   = reg_wr_in && (reg_addr_in == `ADDR_DATA_COMMAND_PORT);
      // reading the clear register is the one action that empties all flags
      clear_all = reg_rd_in && (reg_addr_in == `ADDR_ABORT_CLEAR);

      // two-stage synchronisers; only the second stage is looked at
      d.scl_meta = scl_in;
      d.scl_sync = q.scl_meta;
      d.scl_prev = q.scl_sync;
      d.sda_meta = sda_in;
      d.sda_sync = q.sda_meta;
      scl_rise   = q.scl_sync && !q.scl_prev;

      restart_ok = q.controller_config[`CFG_REPEATED_START_BIT];
      master_on  = q.controller_config[`CFG_MASTER_ENABLE_BIT];
      high_speed = (q.controller_config[`CFG_SPEED_LSB +: 2] == `CFG_SPEED_HIGH);
      ten_bit    = q.target_address_config[`TAR_TEN_BIT_ADDR_BIT];

      // ownership check on each rising clock-line edge, per role
      master_lost = scl_rise && master_tx_drive_in && (q.sda_sync != master_tx_bit_in);
      slave_lost  = scl_rise && slave_tx_active_in && (q.sda_sync != slave_tx_bit_in);

      // level causes; edges of these count as new events
      dis_cause   = master_cmd_pending_in && !master_on;
      hs_cause    = master_cmd_pending_in && !restart_ok && high_speed;
      sbyte_cause = master_cmd_pending_in && !restart_ok
                    && q.target_address_config[`TAR_SBYTE_OR_GCALL_BIT]
                    && q.target_address_config[`TAR_GCALL_VS_SBYTE_BIT];

      set = 16'h0000;
      set[`CAUSE_SLAVE_READ_CONFLICT] = wr_dcmd && slave_tx_active_in
                                        && reg_wdata_in[`DCMD_DIRECTION_BIT];
      set[`CAUSE_SLAVE_BUS_LOSS]      = slave_lost;
      set[`CAUSE_SLAVE_STALE_FLUSH]   = slave_read_req_in && !tx_fifo_empty_in;
      set[`CAUSE_ARBITRATION_LOST]    = master_lost || slave_lost;
      set[`CAUSE_MASTER_DISABLED]     = dis_cause && !q.level_prev[0];
      set[`CAUSE_TEN_BIT_READ_NOREP]  = master_read_issue_in && !restart_ok && ten_bit;
      set[`CAUSE_HIGH_SPEED_NOREP]    = hs_cause && !q.level_prev[1];
      set[`CAUSE_START_BYTE_ACKED]    = master_event_in.start_byte_acked;
      set[`CAUSE_HS_CODE_ACKED]       = master_event_in.hs_code_acked;
      set[`CAUSE_GCALL_READ]          = wr_dcmd && q.gcall_phase
                                        && reg_wdata_in[`DCMD_GCALL_READ_BIT];
      set[`CAUSE_GCALL_UNACKED]       = master_event_in.gcall_unacked;
      set[`CAUSE_DATA_UNACKED]        = master_event_in.data_unacked && master_on;
      set[`CAUSE_TEN_SECOND_UNACKED]  = master_event_in.ten_second_unacked;
      set[`CAUSE_TEN_FIRST_UNACKED]   = master_event_in.ten_first_unacked;
      set[`CAUSE_SEVEN_ADDR_UNACKED]  = master_event_in.seven_addr_unacked;

      // start-byte cause is a level: a new event only on its rise
      evt = set;
      evt[`CAUSE_START_BYTE_NOREP] = sbyte_cause && !q.level_prev[2];

      d.level_prev = {sbyte_cause, hs_cause, dis_cause};

      // general call remembered until the master returns to idle
      if (master_event_in.gcall_sent)
      begin
         d.gcall_phase = 1'b1;
      end
      else if (master_idle_in)
      begin
         d.gcall_phase = 1'b0;
      end

      // set beats a simultaneous clear for every flag but the start-byte one
      d.cause = (clear_all ? 16'h0000 : q.cause) | set;
      // here the clear wins for one cycle and the live cause re-sets it next
      d.cause[`CAUSE_START_BYTE_NOREP] = clear_all ? 1'b0
                                         : (q.cause[`CAUSE_START_BYTE_NOREP] || sbyte_cause);

      // a start-byte cause that outlives a clear raises the status again along with its flag
      d.abort_status = (clear_all ? 1'b0 : q.abort_status) || (|evt)
                       || (!clear_all && sbyte_cause);
      d.flush        = |evt;
      d.master_stop  = (|evt[11:0]) || master_lost;
      d.slave_stop   = (|evt[15:13]);

      // ---------------------------------------------------------------------
      // configuration writes
      // ---------------------------------------------------------------------
      if (wr_ctrl)
      begin
         d.controller_config = reg_wdata_in;
      end
      if (wr_target)
      begin
         d.target_address_config = reg_wdata_in;
      end

      // ---------------------------------------------------------------------
      // reads: data in the cycle after the strobe, zero otherwise
      // ---------------------------------------------------------------------
      d.rdata = 16'h0000;
      if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            `ADDR_CONTROLLER_CONFIG:    d.rdata = q.controller_config;
            `ADDR_TARGET_ADDRESS_CFG:   d.rdata = q.target_address_config;
            `ADDR_ABORT_STATUS:         d.rdata = {15'h0000, q.abort_status};
            `ADDR_TRANSMIT_ABORT_CAUSE: d.rdata = q.cause;
            default:                    d.rdata = 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         q                       <= '0;
         q.controller_config     <= `RESET_CONTROLLER_CONFIG;
         q.target_address_config <= `RESET_TARGET_ADDRESS_CFG;
         q.cause                 <= `RESET_ABORT_CAUSE;
         // idle lines rest high; a zero here would fake a clock-line rise after reset
         q.scl_meta              <= 1'b1;
         q.scl_sync              <= 1'b1;
         q.scl_prev              <= 1'b1;
         q.sda_meta              <= 1'b1;
         q.sda_sync              <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign reg_rdata_out            = q.rdata;
   assign tx_flush_out             = q.flush;
   assign master_stop_out          = q.master_stop;
   assign slave_stop_out           = q.slave_stop;
   assign transmit_abort_event_out = q.abort_status;
   assign master_bus_lost_out      = master_lost;
   assign slave_bus_lost_out       = slave_lost;

endmodule

// ---- tx_abort_params.svh ----
/*
 * Constants of the transmit-abort cause block: register byte addresses,
 * field positions, cause bit positions and reset values.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef TX_ABORT_PARAMS_SVH
`define TX_ABORT_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ADDR_CONTROLLER_CONFIG    32'h50001300
`define ADDR_TARGET_ADDRESS_CFG   32'h50001304
`define ADDR_DATA_COMMAND_PORT    32'h50001310
`define ADDR_ABORT_STATUS         32'h5000134C
`define ADDR_ABORT_CLEAR          32'h50001354
`define ADDR_TRANSMIT_ABORT_CAUSE 32'h50001380

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CFG_MASTER_ENABLE_BIT     0
`define CFG_SPEED_LSB             1
`define CFG_SPEED_HIGH            2'h3
`define CFG_REPEATED_START_BIT    5
`define TAR_GCALL_VS_SBYTE_BIT    10
`define TAR_SBYTE_OR_GCALL_BIT    11
`define TAR_TEN_BIT_ADDR_BIT      12
`define DCMD_DIRECTION_BIT        8
`define DCMD_GCALL_READ_BIT       9

// ----------------------------------------------------------------------
// cause bit positions
// ----------------------------------------------------------------------
`define CAUSE_SLAVE_READ_CONFLICT 15
`define CAUSE_SLAVE_BUS_LOSS      14
`define CAUSE_SLAVE_STALE_FLUSH   13
`define CAUSE_ARBITRATION_LOST    12
`define CAUSE_MASTER_DISABLED     11
`define CAUSE_TEN_BIT_READ_NOREP  10
`define CAUSE_START_BYTE_NOREP    9
`define CAUSE_HIGH_SPEED_NOREP    8
`define CAUSE_START_BYTE_ACKED    7
`define CAUSE_HS_CODE_ACKED       6
`define CAUSE_GCALL_READ          5
`define CAUSE_GCALL_UNACKED       4
`define CAUSE_DATA_UNACKED        3
`define CAUSE_TEN_SECOND_UNACKED  2
`define CAUSE_TEN_FIRST_UNACKED   1
`define CAUSE_SEVEN_ADDR_UNACKED  0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RESET_CONTROLLER_CONFIG   16'h0021
`define RESET_TARGET_ADDRESS_CFG  16'h0000
`define RESET_ABORT_CAUSE         16'h0000

`endif

// ---- tx_abort_pkg.sv ----
/*
 * Types of the transmit-abort cause block.
 * Assumes tx_abort_params.svh for all numeric constants.
 */
package tx_abort_pkg;

   // one-cycle events from the master state machine
   typedef struct packed {
      logic gcall_sent;
      logic hs_code_acked;
      logic start_byte_acked;
      logic gcall_unacked;
      logic data_unacked;
      logic ten_second_unacked;
      logic ten_first_unacked;
      logic seven_addr_unacked;
   } master_event_t;

   // whole state of the block
   typedef struct packed {
      logic [15:0] controller_config;
      logic [15:0] target_address_config;
      logic [15:0] cause;
      logic        abort_status;
      logic        gcall_phase;
      logic        scl_meta;
      logic        scl_sync;
      logic        scl_prev;
      logic        sda_meta;
      logic        sda_sync;
      logic [2:0]  level_prev;
      logic [15:0] rdata;
      logic        flush;
      logic        master_stop;
      logic        slave_stop;
   } abort_state_t;

endpackage

// ---- tx_abort_cause_properties.sv ----
/*
 * Checker of the transmit-abort cause block: register read-back, abort
 * status, bus-loss context and stop pulses.
 * Assumes binding to tx_abort_cause; sees only its ports.
 */
`timescale 1ns/100ps
`include "tx_abort_params.svh"

module tx_abort_cause_properties
   import tx_abort_pkg::*;
(
   // clock, reset and register port
   input wire logic          sys_clk_in,
   input wire logic          nrst_in,
   input wire logic [31:0]   reg_addr_in,
   input wire logic          reg_wr_in,
   input wire logic          reg_rd_in,
   input wire logic [15:0]   reg_rdata_out,
   // event sources
   input wire master_event_t master_event_in,
   input wire logic          master_tx_drive_in,
   input wire logic          slave_read_req_in,
   input wire logic          slave_tx_active_in,
   input wire logic          tx_fifo_empty_in,
   // abort reaction
   input wire logic          tx_flush_out,
   input wire logic          master_stop_out,
   input wire logic          slave_stop_out,
   input wire logic          transmit_abort_event_out,
   input wire logic          master_bus_lost_out,
   input wire logic          slave_bus_lost_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);

   wire logic clr = reg_rd_in && (reg_addr_in == `ADDR_ABORT_CLEAR);

   sequence s_clr_read;
      clr ##1 (reg_rdata_out == 16'h0000);
   endsequence
   sequence s_slave_loss;
      slave_bus_lost_out ##1 transmit_abort_event_out;
   endsequence

   AST_RDATA_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
      else $error("read data not zero outside read slot");
   AST_CLEAR_READ: assert property (clr |-> s_clr_read)
      else $error("clear read returned nonzero");
   AST_STATUS_STICKY: assert property (transmit_abort_event_out && !clr |=> transmit_abort_event_out)
      else $error("abort status dropped without clear");
   AST_MASTER_CAUSE: assert property ((|master_event_in[6:4]) || (|master_event_in[2:0]) |=> transmit_abort_event_out)
      else $error("master cause raised no abort status");
   AST_MASTER_STOP: assert property (master_bus_lost_out || (|master_event_in[2:0]) |=> master_stop_out)
      else $error("master cause raised no master stop");
   AST_FLUSH_PULSE: assert property (slave_read_req_in && !tx_fifo_empty_in |=> tx_flush_out)
      else $error("stale data read raised no flush");
   AST_SLAVE_LOSS: assert property (slave_bus_lost_out |-> s_slave_loss)
      else $error("slave bus loss raised no abort status");
   AST_SLAVE_LOSS_CTX: assert property (slave_bus_lost_out |-> slave_tx_active_in)
      else $error("slave bus loss while slave not sending");
   AST_MASTER_LOSS_CTX: assert property (master_bus_lost_out |-> master_tx_drive_in)
      else $error("master bus loss while master not driving");
   AST_STALE_FLUSH: assert property (slave_read_req_in && !tx_fifo_empty_in |=> transmit_abort_event_out)
      else $error("stale data read raised no abort status");
   AST_FLUSH_STATUS: assert property (tx_flush_out |-> transmit_abort_event_out)
      else $error("flush without abort status");
   AST_SLAVE_STOP_CAUSE: assert property (slave_stop_out |-> $past(slave_bus_lost_out || slave_read_req_in || reg_wr_in))
      else $error("slave stop without slave cause");
endmodule

bind tx_abort_cause tx_abort_cause_properties i_tx_abort_cause_properties (.sys_clk_in, .nrst_in, .reg_addr_in,
   .reg_wr_in, .reg_rd_in, .reg_rdata_out, .master_event_in, .master_tx_drive_in, .slave_read_req_in,
   .slave_tx_active_in, .tx_fifo_empty_in, .tx_flush_out, .master_stop_out, .slave_stop_out, .transmit_abort_event_out,
   .master_bus_lost_out, .slave_bus_lost_out);

// ---- tx_abort_remote_bus.sv ----
/*
 * Remote party on the two-wire bus: runs the clock line inside a frame
 * and holds the data line at the bit the bench asks for.
 * Assumes pull-ups on both lines; nothing else drives them.
 */
`timescale 1ns/100ps

module tx_abort_remote_bus (
   // frame control from the bench
   input  wire logic frame_in,
   input  wire logic bit_in,
   // bus lines seen by the block
   output logic      scl_out,
   output logic      sda_out
);
   logic clk_q = 1'b1;
   // 48 ns period inside a frame only; pull-up holds the line high between frames
   always #24 clk_q = frame_in ? ~clk_q : 1'b1;
   assign scl_out = clk_q;
   // a released data line rests at the pull-up level
   assign sda_out = frame_in ? bit_in : 1'b1;
endmodule

// ---- tx_abort_cause_tb_top.sv ----
/*
 * Self-checking bench of the transmit-abort cause block.
 * Assumes the bound checker and the remote bus model beside the block.
 */
`timescale 1ns/100ps
`include "tx_abort_params.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end

module tx_abort_cause_tb_top;
   import tx_abort_pkg::*;
   logic          sys_clk_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic [31:0]   reg_addr_in = 32'h0;
   logic [15:0]   reg_wdata_in = 16'h0, reg_rdata_out, d;
   logic          scl_in, sda_in, master_cmd_pending_in = 1'b0, master_read_issue_in = 1'b0;
   logic          master_idle_in = 1'b0, master_tx_drive_in = 1'b0, master_tx_bit_in = 1'b1;
   logic          slave_read_req_in = 1'b0, slave_tx_active_in = 1'b0, slave_tx_bit_in = 1'b1;
   logic          tx_fifo_empty_in = 1'b1, frame = 1'b0;
   master_event_t master_event_in = '0;
   int            err_count = 0, num_checks = 0;
   int            pos [7] = '{0, 1, 2, 3, 4, 7, 6};

   always #2.5 sys_clk_in = ~sys_clk_in;

   tx_abort_cause i_tx_abort_cause (.sys_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out, .scl_in, .sda_in, .master_event_in, .master_cmd_pending_in, .master_read_issue_in,
      .master_idle_in, .master_tx_drive_in, .master_tx_bit_in, .slave_read_req_in, .slave_tx_active_in,
      .slave_tx_bit_in, .tx_fifo_empty_in, .tx_flush_out(), .master_stop_out(), .slave_stop_out(),
      .transmit_abort_event_out(), .master_bus_lost_out(), .slave_bus_lost_out());
   tx_abort_remote_bus i_tx_abort_remote_bus (.frame_in(frame), .bit_in(1'b0), .scl_out(scl_in), .sda_out(sda_in));

   // ----------------------------------------------------------------------
   // bus cycles
   // ----------------------------------------------------------------------
   task automatic wr(input logic [31:0] a, input logic [15:0] v);
      @(posedge sys_clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= v;
      reg_wr_in    <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in    <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [15:0] v);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_in   <= 1'b0;
      // data stand in the cycle after the strobe; take them at its closing edge
      @(posedge sys_clk_in);
      v = reg_rdata_out;
   endtask
   task automatic check_rd(input logic [31:0] a, input logic [15:0] e);
      logic [15:0] v;
      rd(a, v);
      `CHK(v, e)
   endtask
   task automatic ev(input master_event_t m);
      @(posedge sys_clk_in);
      master_event_in <= m;
      @(posedge sys_clk_in);
      master_event_in <= '0;
   endtask
   // read the causes, then remove every cause and clear; level causes must go first
   task automatic close_case(input logic [15:0] e);
      // long enough for two link clock rises plus synchroniser latency
      repeat (24) @(posedge sys_clk_in);
      check_rd(`ADDR_TRANSMIT_ABORT_CAUSE, e);
      check_rd(`ADDR_ABORT_STATUS, 16'h0001);
      master_cmd_pending_in <= 1'b0;
      slave_tx_active_in    <= 1'b0;
      master_tx_drive_in    <= 1'b0;
      tx_fifo_empty_in      <= 1'b1;
      frame                 <= 1'b0;
      master_idle_in        <= 1'b1;
      wr(`ADDR_CONTROLLER_CONFIG, 16'h0021);
      wr(`ADDR_TARGET_ADDRESS_CFG, 16'h0000);
      master_idle_in        <= 1'b0;
      repeat (8) @(posedge sys_clk_in);
      rd(`ADDR_ABORT_CLEAR, d);
      check_rd(`ADDR_TRANSMIT_ABORT_CAUSE, 16'h0000);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge sys_clk_in);
      err_count++;
      stop_test;
   end

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      check_rd(`ADDR_TRANSMIT_ABORT_CAUSE, 16'h0000);
      wr(`ADDR_TRANSMIT_ABORT_CAUSE, 16'hFFFF);
      check_rd(`ADDR_TRANSMIT_ABORT_CAUSE, 16'h0000);
      check_rd(32'h500013F0, 16'h0000);
      for (int i = 0; i < 7; i++)
      begin
         ev(master_event_t'(8'h01 << i));
         close_case(16'h0001 << pos[i]);
      end
      ev(master_event_t'(8'h80));
      wr(`ADDR_DATA_COMMAND_PORT, 16'h0200);
      close_case(16'h0020);
      wr(`ADDR_CONTROLLER_CONFIG, 16'h0020);
      master_cmd_pending_in <= 1'b1;
      ev(master_event_t'(8'h08));
      close_case(16'h0800);
      wr(`ADDR_CONTROLLER_CONFIG, 16'h0001);
      wr(`ADDR_TARGET_ADDRESS_CFG, 16'h1000);
      master_read_issue_in <= 1'b1;
      @(posedge sys_clk_in);
      master_read_issue_in <= 1'b0;
      close_case(16'h0400);
      wr(`ADDR_CONTROLLER_CONFIG, 16'h0007);
      master_cmd_pending_in <= 1'b1;
      close_case(16'h0100);
      wr(`ADDR_CONTROLLER_CONFIG, 16'h0001);
      wr(`ADDR_TARGET_ADDRESS_CFG, 16'h0C00);
      master_cmd_pending_in <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      rd(`ADDR_ABORT_CLEAR, d);
      close_case(16'h0200);
      tx_fifo_empty_in  <= 1'b0;
      slave_read_req_in <= 1'b1;
      @(posedge sys_clk_in);
      slave_read_req_in <= 1'b0;
      close_case(16'h2000);
      slave_tx_active_in <= 1'b1;
      wr(`ADDR_DATA_COMMAND_PORT, 16'h0300);
      close_case(16'h8000);
      master_tx_bit_in   <= 1'b0;
      master_tx_drive_in <= 1'b1;
      frame              <= 1'b1;
      repeat (24) @(posedge sys_clk_in);
      check_rd(`ADDR_TRANSMIT_ABORT_CAUSE, 16'h0000);
      master_tx_bit_in   <= 1'b1;
      close_case(16'h1000);
      slave_tx_active_in <= 1'b1;
      frame              <= 1'b1;
      ev(master_event_t'(8'h01));
      close_case(16'h5001);
      stop_test;
   end
endmodule
